// ### src/cmpc_pkg.sv
// Package: register map, field positions and reset values for clock mode and power control
package cmpc_pkg;

    // ********************************************************************
    // Register map (printed offsets are not word multiples: kept as indices)
    // ********************************************************************
    localparam logic [7:0] CMPC_IDX_POWER_CONTROL = 8'h87;
    localparam logic [7:0] CMPC_IDX_SLOW_OSC_CONTROL = 8'hd1;
    localparam logic [7:0] CMPC_IDX_RADIO_MAIN_CONTROL = 8'h10;
    localparam logic [7:0] CMPC_IDX_CLOCK_STATUS = 8'h11;
    localparam logic [11:0] CMPC_ADDR_POWER_CONTROL = {2'b00, CMPC_IDX_POWER_CONTROL, 2'b00};
    localparam logic [11:0] CMPC_ADDR_SLOW_OSC_CONTROL = {2'b00, CMPC_IDX_SLOW_OSC_CONTROL, 2'b00};
    localparam logic [11:0] CMPC_ADDR_RADIO_MAIN_CONTROL = {2'b00, CMPC_IDX_RADIO_MAIN_CONTROL, 2'b00};
    localparam logic [11:0] CMPC_ADDR_CLOCK_STATUS = {2'b00, CMPC_IDX_CLOCK_STATUS, 2'b00};

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int CMPC_PC_RATE_DOUBLE = 7;
    localparam int CMPC_PC_RESERVED_RW = 6;
    localparam int CMPC_PC_FLAG_HIGH = 3;
    localparam int CMPC_PC_FLAG_LOW = 2;
    localparam int CMPC_PC_STOP = 1;
    localparam int CMPC_PC_IDLE = 0;
    localparam int CMPC_SO_EXTERNAL = 2;
    localparam int CMPC_SO_POWERDOWN = 1;
    localparam int CMPC_SO_SELECT = 0;
    localparam int CMPC_RM_CORE_OFF = 1;
    localparam int CMPC_RM_BIAS_OFF = 0;
    localparam int CMPC_RM_RX_ENABLE = 2;

    // ********************************************************************
    // Reset values and fixed bits
    // ********************************************************************
    localparam logic [7:0] CMPC_PC_RESET = 8'h30;
    localparam logic [7:0] CMPC_PC_ONES = 8'h30;
    localparam logic [7:0] CMPC_PC_WMASK = 8'hcf;
    localparam logic [7:0] CMPC_SO_RESET = 8'h02;
    localparam logic [7:0] CMPC_SO_WMASK = 8'h07;
    localparam logic [7:0] CMPC_RM_RESET = 8'h00;
    localparam logic [7:0] CMPC_RM_WMASK = 8'h07;

    // Synchroniser stages inside each clock domain of the switch
    localparam int CMPC_SYNC_STAGES = 2;

endpackage : cmpc_pkg

// ### src/cmpc_glitch_free_mux.sv
// Glitch-free two-source clock switch
`timescale 1ns/1ps
`default_nettype none

module cmpc_glitch_free_mux
(
    input wire logic rst_b,
    input wire logic clk_main,
    input wire logic clk_slow,
    input wire logic sel_slow,
    output logic clk_out,
    output logic on_slow
);
    import cmpc_pkg::*;

    logic [1:0] main_sync_r;
    logic [1:0] slow_sync_r;
    logic main_en_r;
    logic slow_en_r;

    // ********************************************************************
    // Main side: enable drops once the select is seen, returns after the select clears and slow is off
    // ********************************************************************
    // Two stages then enable register on falling edge: 1.5 to 2.5 periods
    always_ff @(posedge clk_main or negedge rst_b)
    begin
        if (!rst_b)
        begin
            main_sync_r <= 2'b11; // Starts set so the main enable holds through reset release
        end
        else
        begin
            main_sync_r <= {main_sync_r[0], ~sel_slow & ~slow_en_r}; // see RQ22
        end
    end

    // Enable changes only while the main clock is low, so no runt pulse
    always_ff @(negedge clk_main or negedge rst_b)
    begin
        if (!rst_b)
        begin
            main_en_r <= 1'b1; // see RQ1
        end
        else
        begin
            main_en_r <= main_sync_r[1]; // see RQ8
        end
    end

    // ********************************************************************
    // Slow side: mirror image, waits until the main enable is off
    // ********************************************************************
    always_ff @(posedge clk_slow or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slow_sync_r <= 2'b00;
        end
        else
        begin
            slow_sync_r <= {slow_sync_r[0], sel_slow & ~main_en_r}; // see RQ22
        end
    end

    always_ff @(negedge clk_slow or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slow_en_r <= 1'b0;
        end
        else
        begin
            slow_en_r <= slow_sync_r[1]; // see RQ4
        end
    end

    // Both enables low in the gap: output held low
    assign clk_out = (clk_main & main_en_r) | (clk_slow & slow_en_r); // see RQ22
    assign on_slow = slow_en_r;

endmodule : cmpc_glitch_free_mux
`default_nettype wire

// ### src/cmpc_clock_mode_power_control.sv
// Clock mode and power control block with APB register access
// Overview of operation
// RQ1: After reset run everything from main oscillator; slow oscillator powered down.
// RQ2: Software clears slow power-down and waits 160 ms before selecting mode 1.
// RQ3: Bypass bit set lets an external 32.768 kHz clock drive the slow input.
// RQ4: Switch to slow clock glitch-free within 2 to 3 slow periods.
// RQ5: In mode 1 software may power down main oscillator via core and bias bits.
// RQ6: Radio receiver cannot be enabled while the slow clock is selected.
// RQ7: Returning to mode 0 needs main oscillator restarted and 5 ms wait.
// RQ8: Switch back to main clock glitch-free within 2 to 3 main periods.
// RQ9: Software should combine idle mode and flash power control in mode 1.
// RQ10: Power control bit 7 doubles serial port 0 rate; resets to 0.
// RQ11: Power control bits 5 and 4 read one; bit 6 read-write, resets 0.
// RQ12: Power control bits 3 and 2 are software flags, reset 0.
// RQ13: Power control bit 1 enters stop mode; resets 0.
// RQ14: Power control bit 0 enters idle mode; resets 0.
// RQ15: Slow oscillator control bits 7 to 3 read zero and ignore writes.
// RQ16: Slow oscillator control bit 2 selects external input; resets 0.
// RQ17: Slow oscillator control bit 1 powers slow oscillator down; resets 1.
// RQ18: Slow oscillator control bit 0 selects clock mode; resets 0.
// RQ19: Idle halts instruction processing, keeps registers and peripherals running.
// RQ20: Any enabled interrupt clears the idle bit.
// RQ21: Stop gates core and peripheral clocks; converter clock and oscillators continue.
// RQ22: Switch synchronises select in both domains and holds output low in between.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module cmpc_clock_mode_power_control
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_main_osc,
    input wire logic slow_osc_internal_clk,
    input wire logic slow_osc_input_pin,
    input wire logic irq_enabled_pending,
    output logic clk_selected,
    output logic clk_core,
    output logic clk_periph,
    output logic clk_converter,
    output logic core_halt,
    output logic serial0_rate_double,
    output logic slow_osc_powerdown,
    output logic slow_osc_external_input,
    output logic main_osc_core_off,
    output logic main_osc_bias_off,
    output logic radio_rx_enable
);
    import cmpc_pkg::*;

    // ********************************************************************
    // Reset release
    // ********************************************************************
    logic [1:0] rst_sync_r;
    logic rst_int_b;

    // Asynchronous assert, release through two flip-flops
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_sync_r <= 2'b00;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_r[1];

    // ********************************************************************
    // Register state
    // ********************************************************************
    typedef enum logic [1:0]
    {
        CMPC_ST_SETUP = 2'b00,
        CMPC_ST_ACCESS = 2'b01
    } cmpc_apb_state_type;

    cmpc_apb_state_type apb_state_r;
    cmpc_apb_state_type apb_state_nxt;
    logic [7:0] power_control_r;
    logic [7:0] power_control_nxt;
    logic [7:0] slow_oscillator_control_r;
    logic [7:0] slow_oscillator_control_nxt;
    logic [7:0] radio_main_control_r;
    logic [7:0] radio_main_control_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic on_slow_r;
    logic on_slow_nxt;
    logic [1:0] on_slow_sync_r;
    logic switch_on_slow;
    logic mux_clk;

    // Byte-lane masked merge of a write into an 8-bit register
    function automatic logic [7:0] cmpc_merge
    (
        input logic [7:0] old_value,
        input logic [7:0] wdata,
        input logic [7:0] wmask,
        input logic lane
    );
        logic [7:0] merged;
        merged = (old_value & ~wmask) | (wdata & wmask);
        return lane ? merged : old_value;
    endfunction : cmpc_merge

    // Address decode shared by read and write
    function automatic logic cmpc_hit(input logic [11:0] addr, input logic [11:0] target);
        return addr == target;
    endfunction : cmpc_hit

    // ********************************************************************
    // APB slave and register next state
    // ********************************************************************
    // Answer in the first access cycle: pready rises one cycle after setup
    always_comb
    begin
        logic wr_go;
        wr_go = 1'b0;
        apb_state_nxt = apb_state_r;
        power_control_nxt = power_control_r;
        slow_oscillator_control_nxt = slow_oscillator_control_r;
        radio_main_control_nxt = radio_main_control_r;
        prdata_nxt = prdata_r;
        pready_nxt = 1'b0;
        pslverr_nxt = 1'b0;
        case (apb_state_r)
            CMPC_ST_SETUP:
            begin
                if (psel && !penable)
                begin
                    apb_state_nxt = CMPC_ST_ACCESS;
                    pready_nxt = 1'b1;
                    prdata_nxt = 32'h0000_0000;
                    if (cmpc_hit(paddr, CMPC_ADDR_POWER_CONTROL))
                    begin
                        prdata_nxt[7:0] = power_control_r | CMPC_PC_ONES; // see RQ11
                    end
                    else if (cmpc_hit(paddr, CMPC_ADDR_SLOW_OSC_CONTROL))
                    begin
                        prdata_nxt[7:0] = slow_oscillator_control_r & CMPC_SO_WMASK; // see RQ15
                    end
                    else if (cmpc_hit(paddr, CMPC_ADDR_RADIO_MAIN_CONTROL))
                    begin
                        prdata_nxt[7:0] = radio_main_control_r;
                    end
                    else if (cmpc_hit(paddr, CMPC_ADDR_CLOCK_STATUS))
                    begin
                        prdata_nxt[0] = on_slow_r;
                    end
                    else
                    begin
                        pslverr_nxt = 1'b1;
                    end
                end
            end
            CMPC_ST_ACCESS:
            begin
                // Write takes effect at the edge where pready is seen high
                wr_go = psel && penable && pwrite && pready_r && !pslverr_r;
                apb_state_nxt = CMPC_ST_SETUP;
                if (wr_go && cmpc_hit(paddr, CMPC_ADDR_POWER_CONTROL))
                begin
                    power_control_nxt = cmpc_merge(power_control_r, pwdata[7:0], CMPC_PC_WMASK,
                                                   pstrb[0]); // see RQ10
                end
                if (wr_go && cmpc_hit(paddr, CMPC_ADDR_SLOW_OSC_CONTROL))
                begin
                    slow_oscillator_control_nxt = cmpc_merge(slow_oscillator_control_r, pwdata[7:0],
                                                             CMPC_SO_WMASK, pstrb[0]); // see RQ18
                end
                if (wr_go && cmpc_hit(paddr, CMPC_ADDR_RADIO_MAIN_CONTROL))
                begin
                    radio_main_control_nxt = cmpc_merge(radio_main_control_r, pwdata[7:0],
                                                        CMPC_RM_WMASK, pstrb[0]); // see RQ5
                end
            end
            default:
            begin
                apb_state_nxt = CMPC_ST_SETUP;
            end
        endcase
        // Interrupt wins over a simultaneous write that sets idle
        if (irq_enabled_pending)
        begin
            power_control_nxt[CMPC_PC_IDLE] = 1'b0; // see RQ20
        end
        // Receiver forced off while mode 1 is selected or still running
        if (slow_oscillator_control_nxt[CMPC_SO_SELECT] || on_slow_r)
        begin
            radio_main_control_nxt[CMPC_RM_RX_ENABLE] = 1'b0; // see RQ6
        end
    end

    // Register update only
    always_ff @(posedge clk_sys or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            apb_state_r <= CMPC_ST_SETUP;
            power_control_r <= CMPC_PC_RESET; // see RQ10
            slow_oscillator_control_r <= CMPC_SO_RESET; // see RQ17
            radio_main_control_r <= CMPC_RM_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            apb_state_r <= apb_state_nxt;
            power_control_r <= power_control_nxt;
            slow_oscillator_control_r <= slow_oscillator_control_nxt;
            radio_main_control_r <= radio_main_control_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ********************************************************************
    // Clock source selection
    // ********************************************************************
    // Bypass picks the pin in place of the internal slow oscillator
    logic slow_clk_src;
    assign slow_clk_src = slow_oscillator_control_r[CMPC_SO_EXTERNAL] ? slow_osc_input_pin
                                                                      : slow_osc_internal_clk; // see RQ3

    // Switch starts on the main clock after reset
    cmpc_glitch_free_mux i_cmpc_glitch_free_mux
    (
        .rst_b(rst_int_b),
        .clk_main(clk_main_osc),
        .clk_slow(slow_clk_src),
        .sel_slow(slow_oscillator_control_r[CMPC_SO_SELECT]), // see RQ4
        .clk_out(mux_clk), // see RQ1
        .on_slow(switch_on_slow)
    );

    // Bring the switch state back to clk_sys for status and receiver lock
    always_comb
    begin
        on_slow_nxt = on_slow_sync_r[1];
    end

    always_ff @(posedge clk_sys or negedge rst_int_b)
    begin
        if (!rst_int_b)
        begin
            on_slow_sync_r <= 2'b00;
            on_slow_r <= 1'b0;
        end
        else
        begin
            on_slow_sync_r <= {on_slow_sync_r[0], switch_on_slow};
            on_slow_r <= on_slow_nxt;
        end
    end

    // ********************************************************************
    // Clock trees and outputs
    // ********************************************************************
    // Gated trees derive from the switch; a flop would halve them, so clocks bypass
    // the flop rule. Stop gates core and peripherals, idle only the core.
    assign clk_selected = mux_clk;
    assign clk_core = mux_clk & ~power_control_r[CMPC_PC_STOP] & ~power_control_r[CMPC_PC_IDLE]; // see RQ19
    assign clk_periph = mux_clk & ~power_control_r[CMPC_PC_STOP]; // see RQ13 RQ21
    assign clk_converter = mux_clk; // see RQ21
    assign core_halt = power_control_r[CMPC_PC_STOP] | power_control_r[CMPC_PC_IDLE]; // see RQ14
    assign serial0_rate_double = power_control_r[CMPC_PC_RATE_DOUBLE]; // see RQ10
    assign slow_osc_powerdown = slow_oscillator_control_r[CMPC_SO_POWERDOWN]; // see RQ17
    assign slow_osc_external_input = slow_oscillator_control_r[CMPC_SO_EXTERNAL]; // see RQ16
    assign main_osc_core_off = radio_main_control_r[CMPC_RM_CORE_OFF]; // see RQ5
    assign main_osc_bias_off = radio_main_control_r[CMPC_RM_BIAS_OFF]; // see RQ5
    assign radio_rx_enable = radio_main_control_r[CMPC_RM_RX_ENABLE]; // see RQ6
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Flags bits 3 and 2 and bit 6 are stored only; no hardware effect. see RQ12

endmodule : cmpc_clock_mode_power_control
`default_nettype wire

// ### verification/cmpc_clock_mode_power_control_props.sv
// Checker: register-output and bus properties of the clock mode and power control block
`timescale 1ns/1ps
`default_nettype none

module cmpc_clock_mode_power_control_props
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial0_rate_double,
    input wire logic slow_osc_powerdown,
    input wire logic slow_osc_external_input
);
    import cmpc_pkg::*;

    // ********************************************************************
    // Helper decode of completed writes
    // ********************************************************************
    logic wr_done;
    logic mapped;
    // A write lands only at the access edge with lane 0 enabled
    assign wr_done = psel && penable && pready && pwrite && pstrb[0];
    assign mapped = paddr inside {CMPC_ADDR_POWER_CONTROL, CMPC_ADDR_SLOW_OSC_CONTROL,
                                  CMPC_ADDR_RADIO_MAIN_CONTROL, CMPC_ADDR_CLOCK_STATUS};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ********************************************************************
    // Properties
    // ********************************************************************
    reset_values_a: assert property (
        $rose(rst_b) |-> slow_osc_powerdown && !serial0_rate_double && !slow_osc_external_input)
        else $error("outputs not at reset values");
    pd_write_a: assert property (
        wr_done && paddr == CMPC_ADDR_SLOW_OSC_CONTROL |=> slow_osc_powerdown == $past(pwdata[1]))
        else $error("slow power-down bit not written");
    ext_write_a: assert property (
        wr_done && paddr == CMPC_ADDR_SLOW_OSC_CONTROL |=> slow_osc_external_input == $past(pwdata[2]))
        else $error("external input bit not written");
    rate_write_a: assert property (
        wr_done && paddr == CMPC_ADDR_POWER_CONTROL |=> serial0_rate_double == $past(pwdata[7]))
        else $error("rate doubler bit not written");
    rate_hold_a: assert property (
        !(wr_done && paddr == CMPC_ADDR_POWER_CONTROL) |=> $stable(serial0_rate_double))
        else $error("rate doubler changed without a write");
    so_hold_a: assert property (
        !(wr_done && paddr == CMPC_ADDR_SLOW_OSC_CONTROL) |=> $stable({slow_osc_powerdown, slow_osc_external_input}))
        else $error("slow oscillator control changed without a write");
    pready_setup_a: assert property (psel && !penable |=> pready)
        else $error("no answer in the cycle after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    unmapped_err_a: assert property (
        psel && !penable && !mapped |=> pslverr && (pwrite || prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
endmodule : cmpc_clock_mode_power_control_props

bind cmpc_clock_mode_power_control cmpc_clock_mode_power_control_props i_cmpc_clock_mode_power_control_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial0_rate_double(serial0_rate_double), .slow_osc_powerdown(slow_osc_powerdown),
    .slow_osc_external_input(slow_osc_external_input)
);

`default_nettype wire

// ### verification/test_clock_mode_power_control.sv
// Testbench: register access, power modes and clock switching of the block
`timescale 1ns/1ps
`default_nettype none

module test_clock_mode_power_control;
    import cmpc_pkg::*;

    // ********************************************************************
    // Signals and clocks
    // ********************************************************************
    logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic clk_main = 1'b0, slow_int = 1'b0, slow_pin = 1'b0, irq = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, clk_sel, clk_core, clk_periph, clk_conv, halt, rate, pd, ext, core_off, bias_off, rx;
    logic src_clk;
    int src = 0, miscompares = 0, compares = 0, core_edges = 0, periph_edges = 0, conv_edges = 0;

    // Oscillators unrelated to the bus clock; the slow ones are scaled down to keep the run short
    always #20 clk_sys = ~clk_sys;
    always #30 clk_main = ~clk_main;
    always #100 slow_int = ~slow_int;
    always #140 slow_pin = ~slow_pin;
    assign src_clk = (src == 0) ? clk_main : ((src == 1) ? slow_int : slow_pin);
    // Edge counters on the core, peripheral and converter trees
    always @(posedge clk_core) core_edges++;
    always @(posedge clk_periph) periph_edges++;
    always @(posedge clk_conv) conv_edges++;

    cmpc_clock_mode_power_control i_cmpc_clock_mode_power_control (
        .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clk_main_osc(clk_main), .slow_osc_internal_clk(slow_int), .slow_osc_input_pin(slow_pin),
        .irq_enabled_pending(irq), .clk_selected(clk_sel), .clk_core(clk_core), .clk_periph(clk_periph),
        .clk_converter(clk_conv), .core_halt(halt), .serial0_rate_double(rate), .slow_osc_powerdown(pd),
        .slow_osc_external_input(ext), .main_osc_core_off(core_off), .main_osc_bias_off(bias_off),
        .radio_rx_enable(rx)
    );

    // ********************************************************************
    // Tasks
    // ********************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic finish_test();
        if (miscompares == 0 && compares > 0)
        begin
            $display("*** PASS ***");
        end
        else
        begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test

    // One bus transfer; an idle cycle follows so two requests never share a time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        check("pready", 32'h1, 32'(pready));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(name, exp, rd);
    endtask : rdc

    // Poll the switch status; the switch takes a few source periods, so a bounded poll
    task automatic wait_status(input logic want);
        int n;
        n = 0;
        do
        begin
            apb(1'b0, CMPC_ADDR_CLOCK_STATUS, 32'h0000_0000);
            n++;
        end
        while (rd[0] !== want && n < 40);
        check("clock_status", 32'(want), rd);
    endtask : wait_status

    // The switched clock must track the chosen source edge for edge
    task automatic follow(input int s);
        src = s;
        repeat (3)
        begin
            @(posedge src_clk);
            #2;
            check("clk_selected_high", 32'h1, 32'(clk_sel));
            @(negedge src_clk);
            #2;
            check("clk_selected_low", 32'h0, 32'(clk_sel));
        end
    endtask : follow

    task automatic count_edges();
        repeat (4) @(posedge clk_sys);
        core_edges = 0;
        periph_edges = 0;
        conv_edges = 0;
        repeat (20) @(posedge clk_sys);
    endtask : count_edges

    // ********************************************************************
    // Test sequence
    // ********************************************************************
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdc("power_control", CMPC_ADDR_POWER_CONTROL, 32'h0000_0030);
        rdc("slow_osc_control", CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0002);
        rdc("clock_status", CMPC_ADDR_CLOCK_STATUS, 32'h0000_0000);
        check("slow_osc_powerdown", 32'h1, 32'(pd));
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_00cc);
        rdc("power_control", CMPC_ADDR_POWER_CONTROL, 32'h0000_00fc);
        check("serial0_rate_double", 32'h1, 32'(rate));
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_0000);
        rdc("power_control", CMPC_ADDR_POWER_CONTROL, 32'h0000_0030);
        apb(1'b1, CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_00f8);
        rdc("slow_osc_control", CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0000);
        pstrb <= 4'h0;
        apb(1'b1, CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0007);
        pstrb <= 4'hf;
        rdc("slow_osc_control", CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0000);
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_0001);
        count_edges();
        check("core_halt", 32'h1, 32'(halt));
        check("periph_running", 32'h1, 32'(periph_edges != 0));
        check("core_edges_idle", 32'h0, 32'(core_edges));
        irq <= 1'b1;
        @(posedge clk_sys);
        irq <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("core_halt", 32'h0, 32'(halt));
        rdc("power_control", CMPC_ADDR_POWER_CONTROL, 32'h0000_0030);
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_0002);
        count_edges();
        check("core_edges", 32'h0, 32'(core_edges));
        check("periph_edges", 32'h0, 32'(periph_edges));
        check("conv_running", 32'h1, 32'(conv_edges != 0));
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_0000);
        apb(1'b1, CMPC_ADDR_RADIO_MAIN_CONTROL, 32'h0000_0004);
        check("radio_rx_enable", 32'h1, 32'(rx));
        apb(1'b1, CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0001);
        wait_status(1'b1);
        follow(1);
        check("radio_rx_enable", 32'h0, 32'(rx));
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_0001);
        check("core_halt_slow", 32'h1, 32'(halt));
        apb(1'b1, CMPC_ADDR_POWER_CONTROL, 32'h0000_0000);
        apb(1'b1, CMPC_ADDR_RADIO_MAIN_CONTROL, 32'h0000_0007);
        rdc("radio_main_control", CMPC_ADDR_RADIO_MAIN_CONTROL, 32'h0000_0003);
        check("main_osc_off", 32'h3, 32'({core_off, bias_off}));
        apb(1'b1, CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0005);
        check("slow_osc_external_input", 32'h1, 32'(ext));
        follow(2);
        apb(1'b1, CMPC_ADDR_RADIO_MAIN_CONTROL, 32'h0000_0000);
        apb(1'b1, CMPC_ADDR_SLOW_OSC_CONTROL, 32'h0000_0004);
        wait_status(1'b0);
        follow(0);
        rdc("unmapped_read", 12'h100, 32'h0000_0000);
        check("unmapped_read_err", 32'h1, 32'(err));
        apb(1'b1, 12'h104, 32'hffff_ffff);
        check("unmapped_write_err", 32'h1, 32'(err));
        finish_test();
    end

    // Watchdog: the sequence needs well under 50 us
    initial
    begin
        #200_000;
        miscompares++;
        finish_test();
    end
endmodule : test_clock_mode_power_control

`default_nettype wire
